// File: common/mmd_defines.vh
// Constants for the memory map address decoder.
// Assumes a 16-bit CPU address bus and 4-Kbyte page granularity.
`ifndef MMD_DEFINES_VH
`define MMD_DEFINES_VH

`define MMD_ADDR_W        16
`define MMD_PAGE_HI       15
`define MMD_PAGE_LO       12
`define MMD_OFS_HI        11
`define MMD_REG_PAGE_RST  4'h1
`define MMD_RAM_PAGE_RST  4'h0
`define MMD_EE_PAGE_DEF   4'hf
`define MMD_REG_SIZE      12'h060
`define MMD_RAM_SIZE      12'h400
`define MMD_EE_BLK        4'he
`define MMD_TST_BLK       4'hd
`define MMD_BOOT_HI       8'hbf
`define MMD_VEC_HI        10'h3ff
`define MMD_VEC_LO        6
`define MMD_BOOT_LO       8
`define MMD_EE_SIZE       13'h0200
`define MMD_TST_SIZE      13'h0100
`define MMD_MODE_SC       2'h0
`define MMD_MODE_EXP      2'h1
`define MMD_MODE_BOOT     2'h2
`define MMD_MODE_TEST     2'h3

`endif

// File: design/mmd_mode_latch.v
// Operating mode capture from the two mode-select inputs.
// Assumes the mode-select pins are synchronous to mclk and stable at reset release.
`timescale 1ns/1ns
`include "mmd_defines.vh"

module mmd_mode_latch (
	input  wire       mclk,
	input  wire       reset_n,
	input  wire       mode_select_a,
	input  wire       mode_select_b,
	output reg  [1:0] mode_r,
	output reg        mode_valid_r
);
	// Asynchronous reset loads constants only; the pins are caught on the first clock after release.
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			mode_r       <= `MMD_MODE_SC;
			mode_valid_r <= 1'b0;
		end else if (!mode_valid_r) begin
			// Mode-select b low selects a special mode, a selects expanded/test.
			mode_r       <= {~mode_select_b, mode_select_a};
			mode_valid_r <= 1'b1;
		end
	end
endmodule

// File: design/mmd_page_hit.v
// Page-relative window compare used for the register, RAM and EEPROM windows and the test block.
// Assumes a 16-bit address and a window that starts at a page offset.
`timescale 1ns/1ns
`include "mmd_defines.vh"

module mmd_page_hit #(
	parameter [11:0] BASE = 12'h000,
	parameter [12:0] SIZE = 13'h060
) (
	input  wire [15:0] addr,
	input  wire [3:0]  page,
	input  wire        enable,
	output wire        hit
);
	wire [12:0] ofs;
	assign ofs = {1'b0, addr[`MMD_OFS_HI:0]} - {1'b0, BASE};
	assign hit = enable && (addr[`MMD_PAGE_HI:`MMD_PAGE_LO] == page) &&
		(addr[`MMD_OFS_HI:0] >= BASE) && (ofs < SIZE);
endmodule

// File: design/mmd_decoder.v
// Memory map address decoder: registers, RAM, EEPROM, boot ROM or external bus.
// Assumes CPU address and strobe are synchronous to mclk; selects appear one cycle later.
`timescale 1ns/1ns
`include "mmd_defines.vh"

// Notes on behaviour
// - Register block of 96 bytes decodes at $1000 after reset.
// - Register block moves to the page given by the register-page field.
// - RAM of 1024 bytes decodes at $0000 after reset.
// - RAM moves to the page given by the RAM-page field.
// - Registers win over RAM in a shared page; low 96 RAM bytes hidden.
// - Enabled EEPROM of 512 bytes decodes at $FE00-$FFFF by default.
// - Expanded and test modes put EEPROM at $xE00 of the configured page.
// - Single-chip and bootstrap force EEPROM on at default place.
// - Special test mode starts with EEPROM out of the map.
// - Bootstrap mode decodes boot ROM over all of $BF00-$BFFF.
// - Bootstrap vector fetches at $FFC0-$FFFF go to the forced-on EEPROM; normal modes have no boot ROM.
// - Special test mode sends vector fetches to the external bus.
// - Special test mode blocks external access to $zD00-$zDFF.
// - Registers and RAM sit at same addresses in expanded and single-chip.
// - Registers fill the first 96 addresses of their page.
// - Operating mode is latched from the two mode-select inputs at reset.
// - Expanded modes send unclaimed addresses out with read/write direction.
module mmd_decoder (
	input  wire        mclk,
	input  wire        reset_n,
	input  wire        mode_select_a,
	input  wire        mode_select_b,
	input  wire [15:0] cpu_addr,
	input  wire        cpu_valid,
	input  wire        cpu_rw,
	input  wire        map_init_we,
	input  wire [3:0]  ram_page_in,
	input  wire [3:0]  reg_page_in,
	input  wire        config_ee_on,
	input  wire [3:0]  eeprom_page_field,
	input  wire        test_ee_map_we,
	input  wire        test_ee_map_on,
	output reg  [1:0]  op_mode_r,
	output reg  [3:0]  ram_page_r,
	output reg  [3:0]  reg_page_r,
	output reg         sel_reg_r,
	output reg         sel_ram_r,
	output reg         sel_boot_r,
	output reg         sel_eeprom_r,
	output reg         sel_ext_r,
	output reg         ext_blocked_r,
	output reg  [15:0] ext_addr_r,
	output reg         ext_rw_r,
	output reg  [11:0] local_ofs_r
);
	localparam [4:0] ST_REG = 5'h01;
	localparam [4:0] ST_RAM = 5'h02;
	localparam [4:0] ST_BOOT = 5'h04;
	localparam [4:0] ST_EE = 5'h08;
	localparam [4:0] ST_EXT = 5'h10;

	wire [1:0] mode;
	wire       mode_valid;
	reg        test_ee_r;
	reg  [3:0] ram_page_nxt;
	reg  [3:0] reg_page_nxt;
	reg  [4:0] pick_nxt;
	reg        blocked_nxt;
	wire       hit_reg;
	wire       hit_ram;
	wire       hit_boot;
	wire       hit_ee;
	wire       hit_tst;
	wire       expanded;
	wire       ee_enable;
	wire [3:0] ee_page;
	wire       is_vector;

	mmd_mode_latch u_mode (
		.mclk          (mclk),
		.reset_n       (reset_n),
		.mode_select_a (mode_select_a),
		.mode_select_b (mode_select_b),
		.mode_r        (mode),
		.mode_valid_r  (mode_valid)
	);

	assign expanded = (mode == `MMD_MODE_EXP) || (mode == `MMD_MODE_TEST);
	// Expanded and test modes keep the EEPROM enable (test also needs test_ee_r); single-chip and bootstrap force it on.
	assign ee_enable = expanded ?
		((mode == `MMD_MODE_TEST) ? (test_ee_r && config_ee_on) : config_ee_on) : 1'b1;
	assign ee_page = expanded ? eeprom_page_field : `MMD_EE_PAGE_DEF;
	assign is_vector = (cpu_addr[`MMD_PAGE_HI:`MMD_VEC_LO] == `MMD_VEC_HI);

	// Same window logic serves every mode, so register and RAM maps agree in expanded and single-chip.
	mmd_page_hit #(.BASE(12'h000), .SIZE({1'b0, `MMD_REG_SIZE})) u_reg_hit (
		.addr   (cpu_addr),
		.page   (reg_page_r),
		.enable (mode_valid),
		.hit    (hit_reg)
	);

	mmd_page_hit #(.BASE(12'h000), .SIZE({1'b0, `MMD_RAM_SIZE})) u_ram_hit (
		.addr   (cpu_addr),
		.page   (ram_page_r),
		.enable (mode_valid),
		.hit    (hit_ram)
	);

	mmd_page_hit #(.BASE({`MMD_EE_BLK, 8'h00}), .SIZE(`MMD_EE_SIZE)) u_ee_hit (
		.addr   (cpu_addr),
		.page   (ee_page),
		.enable (mode_valid && ee_enable),
		.hit    (hit_ee)
	);

	mmd_page_hit #(.BASE({`MMD_TST_BLK, 8'h00}), .SIZE(`MMD_TST_SIZE)) u_tst_hit (
		.addr   (cpu_addr),
		.page   (eeprom_page_field),
		.enable (mode == `MMD_MODE_TEST),
		.hit    (hit_tst)
	);

	// Whole 256-byte page, used or not, belongs to the boot ROM in bootstrap mode only.
	assign hit_boot = mode_valid && (mode == `MMD_MODE_BOOT) &&
		(cpu_addr[`MMD_PAGE_HI:`MMD_BOOT_LO] == `MMD_BOOT_HI);

	always @* begin
		ram_page_nxt = ram_page_r;
		reg_page_nxt = reg_page_r;
		if (map_init_we) begin
			ram_page_nxt = ram_page_in;
			reg_page_nxt = reg_page_in;
		end
	end

	always @* begin
		pick_nxt    = 5'h00;
		blocked_nxt = 1'b0;
		if (cpu_valid && mode_valid) begin
			if (mode == `MMD_MODE_TEST && is_vector) begin
				pick_nxt = ST_EXT;
			end else if (hit_reg) begin
				pick_nxt = ST_REG;
			end else if (hit_ram) begin
				pick_nxt = ST_RAM;
			end else if (hit_boot) begin
				pick_nxt = ST_BOOT;
			end else if (hit_ee) begin
				pick_nxt = ST_EE;
			end else if (expanded) begin
				if (hit_tst) begin
					blocked_nxt = 1'b1;
				end else begin
					pick_nxt = ST_EXT;
				end
			end
		end
	end

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ram_page_r <= `MMD_RAM_PAGE_RST;
			reg_page_r <= `MMD_REG_PAGE_RST;
			test_ee_r  <= 1'b0;
		end else begin
			ram_page_r <= ram_page_nxt;
			reg_page_r <= reg_page_nxt;
			if (test_ee_map_we && mode == `MMD_MODE_TEST) begin
				test_ee_r <= test_ee_map_on;
			end
		end
	end

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			op_mode_r     <= `MMD_MODE_SC;
			sel_reg_r     <= 1'b0;
			sel_ram_r     <= 1'b0;
			sel_boot_r    <= 1'b0;
			sel_eeprom_r  <= 1'b0;
			sel_ext_r     <= 1'b0;
			ext_blocked_r <= 1'b0;
			ext_addr_r    <= 16'h0000;
			ext_rw_r      <= 1'b1;
			local_ofs_r   <= 12'h000;
		end else begin
			op_mode_r     <= mode;
			sel_reg_r     <= pick_nxt[0];
			sel_ram_r     <= pick_nxt[1];
			sel_boot_r    <= pick_nxt[2];
			sel_eeprom_r  <= pick_nxt[3];
			sel_ext_r     <= pick_nxt[4];
			ext_blocked_r <= blocked_nxt;
			local_ofs_r   <= cpu_addr[`MMD_OFS_HI:0];
			case (pick_nxt)
				ST_EXT: begin
					ext_addr_r <= cpu_addr;
					ext_rw_r   <= cpu_rw;
				end
				default: begin
					ext_rw_r <= 1'b1;
				end
			endcase
		end
	end
endmodule

// File: test/mmd_decoder_chk.sv
// Checker for the decoder selects, bound to every decoder instance.
// Assumes requests start from the third edge after reset release.
`timescale 1ns/1ns
module mmd_decoder_chk (
	input wire        mclk,
	input wire        reset_n,
	input wire [15:0] cpu_addr,
	input wire        cpu_valid,
	input wire        cpu_rw,
	input wire [3:0]  eeprom_page_field,
	input wire [1:0]  op_mode_r,
	input wire [3:0]  ram_page_r,
	input wire [3:0]  reg_page_r,
	input wire        sel_reg_r,
	input wire        sel_ram_r,
	input wire        sel_boot_r,
	input wire        sel_eeprom_r,
	input wire        sel_ext_r,
	input wire        ext_blocked_r,
	input wire [15:0] ext_addr_r,
	input wire        ext_rw_r
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	wire reg_hit = cpu_addr[15:12] == reg_page_r && cpu_addr[11:0] < 12'h060;
	wire ram_hit = cpu_addr[15:12] == ram_page_r && cpu_addr[11:0] < 12'h400;
	wire own_hit = reg_hit || ram_hit;
	a_reg_select: assert property (cpu_valid && reg_hit |=> sel_reg_r)
		else $error("register block not selected");
	a_ram_select: assert property (cpu_valid && ram_hit && !reg_hit |=> sel_ram_r)
		else $error("ram not selected");
	a_one_select: assert property ($onehot0({sel_reg_r, sel_ram_r, sel_boot_r, sel_eeprom_r, sel_ext_r, ext_blocked_r}))
		else $error("more than one select");
	a_boot_range: assert property (cpu_valid && op_mode_r == 2'h2 && cpu_addr[15:8] == 8'hbf && !own_hit |=> sel_boot_r)
		else $error("boot rom not selected");
	a_boot_only: assert property (sel_boot_r |-> op_mode_r == 2'h2)
		else $error("boot rom outside bootstrap");
	a_test_vector: assert property (cpu_valid && op_mode_r == 2'h3 && cpu_addr >= 16'hffc0 |=> sel_ext_r)
		else $error("test vector not external");
	a_test_block: assert property (cpu_valid && op_mode_r == 2'h3 && cpu_addr[15:12] == eeprom_page_field
		&& cpu_addr[11:8] == 4'hd && !own_hit |=> ext_blocked_r && !sel_ext_r)
		else $error("blocked range went out");
	a_ext_follow: assert property (sel_ext_r |-> ext_addr_r == $past(cpu_addr) && ext_rw_r == $past(cpu_rw))
		else $error("external address or direction wrong");
	a_no_ext: assert property (!op_mode_r[0] |-> !sel_ext_r && !ext_blocked_r)
		else $error("external access in single-chip");
	a_ee_forced: assert property (cpu_valid && !op_mode_r[0] && cpu_addr[15:9] == 7'h7f && !own_hit |=> sel_eeprom_r)
		else $error("eeprom not forced on");
endmodule
bind mmd_decoder mmd_decoder_chk chk (.*);

// File: test/mmd_cpu_model.sv
// CPU side model: presents one address request per call.
// Assumes put is called just after a falling clock edge.
`timescale 1ns/1ns
module mmd_cpu_model (
	output reg [15:0] cpu_addr,
	output reg        cpu_valid,
	output reg        cpu_rw
);
	initial begin
		cpu_addr = 16'h0000;
		cpu_valid = 1'b0;
		cpu_rw = 1'b1;
	end
	task put(input [15:0] a, input v, input r);
		begin
			// An idle bus shows a changing address so a stale one is never taken for a request.
			cpu_addr = v ? a : ~cpu_addr;
			cpu_valid = v;
			cpu_rw = r;
		end
	endtask
endmodule

// File: test/test_memory_map_address_decoder.sv
// Self-checking bench: every mode, default and moved pages, one request per cycle.
// Assumes the one-cycle select latency of the decoder.
`timescale 1ns/1ns
module test_memory_map_address_decoder;
	reg         mclk = 1'b0;
	reg         reset_n = 1'b0;
	reg         mode_select_a = 1'b0;
	reg         mode_select_b = 1'b1;
	reg         map_init_we = 1'b0;
	reg  [3:0]  ram_page_in = 4'h0;
	reg  [3:0]  reg_page_in = 4'h1;
	reg         config_ee_on = 1'b1;
	reg  [3:0]  eeprom_page_field = 4'h7;
	reg         test_ee_map_we = 1'b0;
	reg         test_ee_map_on = 1'b0;
	wire [15:0] cpu_addr, ext_addr_r;
	wire        cpu_valid, cpu_rw, sel_reg_r, sel_ram_r, sel_boot_r, sel_eeprom_r, sel_ext_r, ext_blocked_r, ext_rw_r;
	wire [1:0]  op_mode_r;
	wire [3:0]  ram_page_r, reg_page_r;
	wire [11:0] local_ofs_r;
	reg  [5:0]  ex;
	reg  [15:0] pa;
	reg         pv = 1'b0;
	reg         pr;
	integer     fail_count = 0, comparisons = 0, m, k, i, rp, gp, ton;
	reg  [15:0] tbl [0:14] = '{16'h1000, 16'h105f, 16'h1060, 16'h0000, 16'h03ff, 16'h0400, 16'hbf00,
		16'hbfff, 16'hfe00, 16'hffff, 16'hffc0, 16'h7e00, 16'h7d00, 16'h7dff, 16'h8000};
	mmd_cpu_model cpu (.*);
	mmd_decoder uut (.*);
	always #50 mclk = ~mclk;
	function [5:0] model(input [15:0] x);
		begin
			if (m == 3 && x >= 16'hffc0) model = 6'h02;
			else if (x[15:12] == gp && x[11:0] < 12'h060) model = 6'h20;
			else if (x[15:12] == rp && x[11:0] < 12'h400) model = 6'h10;
			else if (m == 2 && x[15:8] == 8'hbf) model = 6'h08;
			else if (m % 2 == 0 ? x[15:9] == 7'h7f : config_ee_on && (m == 1 || ton) && x[15:12] == eeprom_page_field
				&& x[11:9] == 3'h7) model = 6'h04;
			else if (m == 3 && x[15:12] == eeprom_page_field && x[11:8] == 4'hd) model = 6'h01;
			else model = m % 2 ? 6'h02 : 6'h00;
		end
	endfunction
	task chk(input [23:0] nm, input [16:0] e, input [16:0] g);
		begin
			comparisons = comparisons + 1;
			if (e !== g) begin
				fail_count = fail_count + 1;
				$display("MISMATCH %s expected %h got %h", nm, e, g);
			end
		end
	endtask
	task step(input [15:0] na, input nv);
		begin
			@(negedge mclk);
			if (pv) begin
				chk("sel", ex, {sel_reg_r, sel_ram_r, sel_boot_r, sel_eeprom_r, sel_ext_r, ext_blocked_r});
				chk("ofs", pa[11:0], local_ofs_r);
				if (ex == 6'h02) chk("ext", {pr, pa}, {ext_rw_r, ext_addr_r});
			end
			pa = na;
			pv = nv;
			pr = $urandom % 2;
			ex = model(na);
			cpu.put(na, nv, pr);
		end
	endtask
	task stop_test;
		begin
			if (fail_count == 0 && comparisons > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	initial begin
		i = $urandom(37);
		for (m = 0; m < 4; m = m + 1) begin
			reset_n = 1'b0;
			mode_select_b = ~m[1];
			mode_select_a = m[0];
			ton = 0;
			rp = 0;
			gp = 1;
			// Loaded enable and pages sit on the inputs before any write, so a leak shows up.
			test_ee_map_on = 1'b1;
			ram_page_in = 4'($urandom);
			reg_page_in = ram_page_in;
			repeat (16) @(negedge mclk);
			reset_n = 1'b1;
			repeat (2) @(negedge mclk);
			chk("mod", m, op_mode_r);
			for (k = 0; k < 2; k = k + 1) begin
				chk("pgs", {rp[3:0], gp[3:0]}, {ram_page_r, reg_page_r});
				for (i = 0; i < 60; i = i + 1)
					step(i < 15 ? tbl[i] : {(i % 2 ? gp[3:0] : tbl[i % 15][15:12]), 12'($urandom)}, 1'b1);
				step(16'h0000, 1'b0);
				map_init_we = 1'b1;
				test_ee_map_we = 1'b1;
				@(negedge mclk);
				map_init_we = 1'b0;
				test_ee_map_we = 1'b0;
				rp = ram_page_in;
				gp = reg_page_in;
				ton = 1;
			end
		end
		stop_test;
	end
endmodule
